//--- sim/can_interrupt_flag_register_tb_top.sv
// Purpose: self-checking bench of the flag register over apb
// Assumes: one wait state is not relied on, ready is awaited
// Notes: reads queue their expected value, a monitor compares
`timescale 1ns/10ps
module can_interrupt_flag_register_tb_top;
  reg mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, ctrl_busy = 1;
  reg bus_activity = 0, wake_pin = 0;
  reg [7:0] rx_err_cnt = 8'h00;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, e;
  wire [31:0] prdata;
  wire pready, pslverr, can_irq_n, host_irq, bus_err_evt, arb_loss_evt, err_status;
  wire bus_status, overrun_status, tx_buf_released, rx_release_cmd, sleeping;
  wire [7:0] tx_err_cnt;
  wire [6:0] rx_msg_queue_count;
  logic [31:0] q[$];
  int miscompares = 0, checked = 0, i;
  always #2 mclk = ~mclk;
  cifr_engine_model u_cifr_engine_model (.mclk, .bus_err_evt, .arb_loss_evt, .tx_err_cnt,
    .err_status, .bus_status, .overrun_status, .tx_buf_released, .rx_msg_queue_count,
    .rx_release_cmd);
  cifr_top u_cifr_top (.mclk, .arst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bus_err_evt, .arb_loss_evt,
    .bus_activity, .rx_release_cmd, .tx_err_cnt, .rx_err_cnt, .err_status,
    .bus_status, .overrun_status, .tx_buf_released, .rx_msg_queue_count, .ctrl_busy,
    .wake_pin, .can_irq_n, .sleeping, .host_irq);
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    if (!w) q.push_back(d);
    @(posedge mclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, w ? d : 32'h0};
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  always @(posedge mclk)
  begin
    if (pready === 1'b1 && !pwrite) chk("prdata", q.pop_front(), prdata);
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #20000 miscompares++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(50));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    apb(0, 12'h010, 32'h0);
    apb(0, 12'h00c, 32'h0);
    apb(1, 12'h00c, 32'hff);
    apb(0, 12'h00c, 32'h0);
    apb(0, 12'h004, 32'h0);
    $display("test registers done");
    apb(1, 12'h020, 32'h2);
    apb(1, 12'h028, 32'h1);
    @(posedge mclk) chk("host_irq", 1, host_irq);
    apb(1, 12'h024, 32'h3);
    @(posedge mclk) chk("host_irq", 0, host_irq);
    $display("test interrupt done");
    for (i = 0; i < 6; i++)
    begin
      e = $urandom & 32'hff;
      apb(1, 12'h010, e);
      apb(1, 12'h028, 32'h1);
      u_cifr_engine_model.burst;
      // last edge events land one edge after the burst ends
      repeat (2) @(posedge mclk);
      chk("can_irq_n", e == 0, can_irq_n);
      apb(0, 12'h00c, e);
      apb(0, 12'h00c, e & 1);
      @(posedge mclk) chk("can_irq_n", !e[0], can_irq_n);
      u_cifr_engine_model.release_one(7'h01);
      apb(0, 12'h00c, e & 1);
      u_cifr_engine_model.release_one(7'h00);
      apb(0, 12'h00c, 32'h0);
      @(posedge mclk) chk("can_irq_n", 1, can_irq_n);
    end
    $display("test flags done");
    apb(1, 12'h010, 32'h1);
    u_cifr_engine_model.burst;
    apb(0, 12'h00c, 32'h1);
    @(posedge mclk) chk("can_irq_n", 0, can_irq_n);
    apb(1, 12'h010, 32'h0);
    @(posedge mclk) chk("can_irq_n", 1, can_irq_n);
    $display("test enable drop done");
    ctrl_busy <= 1'b0;
    apb(1, 12'h010, 32'h30);
    apb(1, 12'h028, 32'h1);
    @(posedge mclk) chk("sleeping", 1, sleeping);
    wake_pin <= 1'b1;
    // two synchroniser flops, then the wake event
    repeat (4) @(posedge mclk);
    apb(0, 12'h00c, 32'h10);
    chk("sleeping", 0, sleeping);
    wake_pin <= 1'b0;
    apb(1, 12'h028, 32'h1);
    bus_activity <= 1'b1;
    @(posedge mclk) bus_activity <= 1'b0;
    apb(0, 12'h00c, 32'h10);
    chk("sleeping", 0, sleeping);
    rx_err_cnt <= {1'b1, 7'($urandom)};
    apb(0, 12'h00c, 32'h20);
    rx_err_cnt <= 8'h00;
    apb(0, 12'h00c, 32'h20);
    $display("test wake and passive done");
    wrap_up;
  end
endmodule // can_interrupt_flag_register_tb_top

//--- sim/cifr_engine_model.sv
// Purpose: protocol engine model feeding event and status lines
// Assumes: all lines change just after a rising edge
// Notes: each burst returns every level but rx_msg_queue_count, left at two, to idle so runs repeat cleanly
`timescale 1ns/10ps
module cifr_engine_model (
  input wire       mclk,
  output reg       bus_err_evt,
  output reg       arb_loss_evt,
  output reg [7:0] tx_err_cnt,
  output reg       err_status,
  output reg       bus_status,
  output reg       overrun_status,
  output reg       tx_buf_released,
  output reg [6:0] rx_msg_queue_count,
  output reg       rx_release_cmd
);
  initial {bus_err_evt, arb_loss_evt, tx_err_cnt, err_status, bus_status} = 12'h000;
  initial {overrun_status, tx_buf_released, rx_msg_queue_count, rx_release_cmd} = 10'h100;
  // ****************************************
  // every flag source except wake, two messages queued
  // ****************************************
  task burst;
    @(posedge mclk) {bus_err_evt, arb_loss_evt, tx_err_cnt} <= 10'h380;
    {overrun_status, err_status, bus_status, tx_buf_released} <= 4'he;
    rx_msg_queue_count <= 7'h02;
    @(posedge mclk) {bus_err_evt, arb_loss_evt} <= 2'h0;
    @(posedge mclk) tx_err_cnt <= 8'h00;
    {overrun_status, err_status, bus_status, tx_buf_released} <= 4'h1;
  endtask
  task release_one(input [6:0] left);
    @(posedge mclk) rx_release_cmd <= 1'b1;
    rx_msg_queue_count <= left;
    @(posedge mclk) rx_release_cmd <= 1'b0;
  endtask
endmodule // cifr_engine_model

//--- sim/cifr_properties.sv
// Purpose: port checks of the can interrupt flag register
// Assumes: ce held high by the bench
// Notes: enables are internal, so checks lean on bus reads
`timescale 1ns/10ps
// ****************************************
// checker
// ****************************************
module cifr_chk (
  input wire        mclk,
  input wire        arst_n,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        ctrl_busy,
  input wire        can_irq_n,
  input wire        sleeping
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable && !pready && ce;
  a_rdy_one_wait: assert property (acc |=> pready) else $error("no ready after access");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("ready held high");
  a_err_with_rdy: assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_err: assert property (acc && paddr == 12'h004 |=> pslverr)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_flags_ro_ok:
    assert property (acc && pwrite && paddr == 12'h00c |=> !pslverr)
      else $error("flag write flagged as error");
  a_irq_on_flags:
    assert property (pready && !pwrite && paddr == 12'h00c && prdata[7:1] != 7'h00
      |-> $past(can_irq_n) == 1'b0) else $error("flags set without interrupt");
  a_sleep_refused:
    assert property (acc && pwrite && paddr == 12'h028 && pwdata[0] && ctrl_busy
      && !sleeping |=> !sleeping [*2]) else $error("sleep entered while busy");
endmodule // cifr_chk
bind cifr_top cifr_chk u_chk (.mclk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .ctrl_busy, .can_irq_n, .sleeping);

//--- verilog/cifr_consts.vh
// Purpose: constants of the can interrupt flag register block
// Assumes: apb slave with 32-bit data, one word per register
// Notes: printed offset 3 is not a multiple of four, so byte address is index*4
`ifndef CIFR_CONSTS_VH
`define CIFR_CONSTS_VH

// ****************************************
// register indices and address width
// ****************************************
`define CIFR_IDX_FLAGS     4'h3
`define CIFR_IDX_ENABLE    4'h4
`define CIFR_IDX_MASK      4'h8
`define CIFR_IDX_STATUS    4'h9
`define CIFR_IDX_SLEEP     4'ha
`define CIFR_ADDR_W        12

// ****************************************
// flag bit positions
// ****************************************
`define CIFR_BIT_BUSF      7
`define CIFR_BIT_ARB       6
`define CIFR_BIT_PASSIVE   5
`define CIFR_BIT_WAKE      4
`define CIFR_BIT_OVR       3
`define CIFR_BIT_WARN      2
`define CIFR_BIT_TXREL     1
`define CIFR_BIT_RX        0

// ****************************************
// reset values and error-passive limit
// ****************************************
`define CIFR_RST_FLAGS     8'h00
`define CIFR_RST_ENABLE    8'h00
`define CIFR_RST_MASK      2'h0
`define CIFR_RST_STATUS    2'h0
`define CIFR_PASSIVE_LIMIT 8'h7f

`endif

//--- verilog/cifr_sync.v
// Purpose: two-flop synchroniser for a vector of pin-side levels
// Assumes: inputs are levels that stay stable for several mclk cycles
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps

module cifr_sync #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         arst_n,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else if (ce)
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // cifr_sync

//--- verilog/cifr_top.v
// Purpose: interrupt flag register of a stand-alone can controller, apb slave
// Assumes: event inputs are one-cycle pulses on mclk; status levels on mclk
// Notes: second interrupt output groups flag and host-error events
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "cifr_consts.vh"

module cifr_top (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        ce,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // events from the protocol engine, same clock
  input  wire        bus_err_evt,
  input  wire        arb_loss_evt,
  input  wire        bus_activity,
  input  wire        rx_release_cmd,
  input  wire [7:0]  tx_err_cnt,
  input  wire [7:0]  rx_err_cnt,
  input  wire        err_status,
  input  wire        bus_status,
  input  wire        overrun_status,
  input  wire        tx_buf_released,
  input  wire [6:0]  rx_msg_queue_count,
  input  wire        ctrl_busy,
  // pin-side wake line from the transceiver
  input  wire        wake_pin,
  output reg         can_irq_n,
  output reg         sleeping,
  output reg         host_irq
);

  // ****************************************
  // state
  // ****************************************
  reg  [7:1] flags;
  reg  [7:0] enables;
  reg  [1:0] mask;
  reg  [1:0] status;
  reg        rx_hold;
  reg        prev_passive;
  reg        prev_err;
  reg        prev_bus;
  reg        prev_ovr;
  reg        prev_tx;
  wire [0:0] wake_sync;

  wire       passive_now;
  wire       rx_flag;
  wire [7:0] flag_view;
  wire [7:1] set_evt;
  wire       apb_acc;
  wire       wr;
  wire       rd;
  wire       word_ok;
  wire [3:0] idx;
  wire       hit_flags;
  wire       hit_enable;
  wire       hit_mask;
  wire       hit_status;
  wire       hit_sleep;
  wire       mapped;
  wire       sleep_req;
  wire       sleep_refused;
  reg  [1:0] next_status;
  reg  [7:1] next_flags;
  reg  [31:0] rd_word;

  cifr_sync #(
    .W (1)
  ) u_wake_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ce     (ce),
    .din    (wake_pin),
    .dout   (wake_sync)
  );

  // ****************************************
  // apb decode
  // ****************************************
  assign apb_acc    = psel && penable && !pready;
  assign wr         = apb_acc && pwrite;
  assign rd         = apb_acc && !pwrite;
  assign word_ok    = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h00);
  assign idx        = paddr[5:2];
  assign hit_flags  = word_ok && (idx == `CIFR_IDX_FLAGS);
  assign hit_enable = word_ok && (idx == `CIFR_IDX_ENABLE);
  assign hit_mask   = word_ok && (idx == `CIFR_IDX_MASK);
  assign hit_status = word_ok && (idx == `CIFR_IDX_STATUS);
  assign hit_sleep  = word_ok && (idx == `CIFR_IDX_SLEEP);
  assign mapped     = hit_flags | hit_enable | hit_mask | hit_status | hit_sleep;

  // ****************************************
  // event detection
  // ****************************************
  assign passive_now = (tx_err_cnt > `CIFR_PASSIVE_LIMIT) ||
                       (rx_err_cnt > `CIFR_PASSIVE_LIMIT);

  assign sleep_req     = wr && hit_sleep && pwdata[0] && !sleeping;
  assign sleep_refused = sleep_req && (ctrl_busy || !can_irq_n);

  assign set_evt[`CIFR_BIT_BUSF]    = bus_err_evt && enables[`CIFR_BIT_BUSF];
  assign set_evt[`CIFR_BIT_ARB]     = arb_loss_evt && enables[`CIFR_BIT_ARB];
  assign set_evt[`CIFR_BIT_PASSIVE] = (passive_now != prev_passive) &&
                                      enables[`CIFR_BIT_PASSIVE];
  assign set_evt[`CIFR_BIT_WAKE]    = enables[`CIFR_BIT_WAKE] &&
                                      ((sleeping && (bus_activity || wake_sync[0])) ||
                                       sleep_refused);
  assign set_evt[`CIFR_BIT_OVR]     = overrun_status && !prev_ovr &&
                                      enables[`CIFR_BIT_OVR];
  assign set_evt[`CIFR_BIT_WARN]    = ((err_status != prev_err) ||
                                       (bus_status != prev_bus)) &&
                                      enables[`CIFR_BIT_WARN];
  assign set_evt[`CIFR_BIT_TXREL]   = tx_buf_released && !prev_tx &&
                                      enables[`CIFR_BIT_TXREL];

  assign rx_flag   = (rx_msg_queue_count != 7'h00) && enables[`CIFR_BIT_RX] &&
                     !rx_hold;
  assign flag_view = {flags, rx_flag};

  always @*
  begin
    next_flags = ((rd && hit_flags) ? 7'h00 : flags) | set_evt;
    next_status = status;
    if (wr && hit_status)
    begin
      next_status = status & ~pwdata[1:0];
    end
    next_status = next_status | {sleep_refused, set_evt != 7'h00};
  end

  always @*
  begin
    rd_word = 32'h0000_0000;
    if (hit_flags)
    begin
      rd_word[7:0] = flag_view;
    end
    else if (hit_enable)
    begin
      rd_word[7:0] = enables;
    end
    else if (hit_mask)
    begin
      rd_word[1:0] = mask;
    end
    else if (hit_status)
    begin
      rd_word[1:0] = status;
    end
    else if (hit_sleep)
    begin
      rd_word[0] = sleeping;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags        <= 7'h00;
      enables      <= `CIFR_RST_ENABLE;
      mask         <= `CIFR_RST_MASK;
      status       <= `CIFR_RST_STATUS;
      rx_hold      <= 1'b0;
      prev_passive <= 1'b0;
      prev_err     <= 1'b0;
      prev_bus     <= 1'b0;
      prev_ovr     <= 1'b0;
      prev_tx      <= 1'b1;
      sleeping     <= 1'b0;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      can_irq_n    <= 1'b1;
      host_irq     <= 1'b0;
    end
    else if (ce)
    begin
      flags        <= next_flags;
      status       <= next_status;
      rx_hold      <= rx_release_cmd;
      prev_passive <= passive_now;
      prev_err     <= err_status;
      prev_bus     <= bus_status;
      prev_ovr     <= overrun_status;
      prev_tx      <= tx_buf_released;
      pready       <= apb_acc;
      pslverr      <= apb_acc && !mapped;
      if (rd)
      begin
        prdata <= rd_word;
      end
      if (wr && hit_enable)
      begin
        enables <= pwdata[7:0];
      end
      if (wr && hit_mask)
      begin
        mask <= pwdata[1:0];
      end
      // wake clears sleep; refused request never enters sleep
      if (sleeping && (bus_activity || wake_sync[0]))
      begin
        sleeping <= 1'b0;
      end
      else if (wr && hit_sleep)
      begin
        sleeping <= pwdata[0] && !sleep_refused;
      end
      can_irq_n <= !((next_flags != 7'h00) ||
                     ((rx_msg_queue_count != 7'h00) && !rx_release_cmd &&
                      ((wr && hit_enable) ? pwdata[`CIFR_BIT_RX] :
                       enables[`CIFR_BIT_RX])));
      host_irq  <= (next_status & mask) != 2'h0;
    end
  end

endmodule // cifr_top
